// ---- dmsi_serial.sv ----
// dual mode serial interface: registers, transmitter and receiver
// Behaviour
// - two-bit mode field: async 8, async 7, sync slave, sync master; reset 00
// - two-bit clock source: timer, osc/4, osc/8, osc/16; reset 00
// - sync slave ignores clock source and shifts on external clock
// - parity enable adds parity on transmit and checks msb on receive
// - parity only in asynchronous modes
// - odd select picks odd parity, else even; reset 0
// - tx_enable enables transmitter; readable, reset 0
// - tx_trigger starts send after data load; reads busy; write 0 no effect
// - rx_enable enables receiver; readable, reset 0
// - sync modes: writing rx_trigger starts next character reception
// - sync slave: slave_ready_n goes low when rx_trigger written
// - async: rx_trigger marks buffer empty; new character before it sets overrun
// - rx_trigger reads 1 while receiving; write 0 no effect; reset 0
// - async 7-bit: data msb is not transmitted
// - async: shift register feeds separate receive buffer
// - async 7-bit with parity: buffer msb loaded with 0
// - overrun flag set on overrun, cleared by writing 1
// - parity mismatch sets parity error flag, cleared by writing 1
// - stop bit sampled 0 sets framing error flag, cleared by writing 1
// - error flags zero at reset and while rx_enable is 0
// - two-bit interrupt priority field, reset 00
// - 1 bits drive high, sampled high stored as 1
// - tx done flag on send end, rx done flag on buffer load
// - rx error flag on any parity, framing or overrun error
`timescale 1ns/1ps
`default_nettype none

module dmsi_serial
	import dmsi_pkg::*;
(
	// clock and reset
	input  wire logic          i_mclk,
	input  wire logic          i_rst,
	// register port
	input  wire dmsi_bus_t     i_bus,
	output logic [7:0]         o_rdata,
	// serial link
	input  wire dmsi_link_in_t i_link,
	output logic               o_serial_out,
	output logic               o_sclk_out,
	output logic               o_sclk_oe,
	output logic               o_slave_ready_n,
	// interrupt request level toward the controller
	output logic [1:0]         o_irq_level
);

	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);

	////////////////////////////////////////////////////////////////////
	// registers
	dmsi_mode_t  mode;
	dmsi_csrc_t  csrc;
	logic        par_en, par_odd, tx_en, rx_en, tx_busy, rx_busy;
	logic        ovr, perr, ferr, tx_done, rx_done, rx_err;
	logic [1:0]  prio;
	logic [7:0]  tx_data, rx_buf, rx_shift_out;
	logic        rx_buf_full;

	logic wr_mode, wr_ctrl, wr_data, wr_evt, wr_prio;
	assign wr_mode = i_bus.wr && i_bus.addr == ADDR_MODE;
	assign wr_ctrl = i_bus.wr && i_bus.addr == ADDR_CTRL;
	assign wr_data = i_bus.wr && i_bus.addr == ADDR_DATA;
	assign wr_evt  = i_bus.wr && i_bus.addr == ADDR_EVENTS;
	assign wr_prio = i_bus.wr && i_bus.addr == ADDR_IRQ_PRIO;

	logic is_async, tx_start, rx_start;
	assign is_async = mode[1];
	assign tx_start = wr_ctrl && i_bus.wdata[TX_TRIGGER_BIT] && tx_en && !tx_busy;
	assign rx_start = wr_ctrl && i_bus.wdata[RX_TRIGGER_BIT] && rx_en;

	// a 1 written to a flag clears it; a set in the same cycle still wins
	function automatic logic flag_next(input logic cur, input logic set, input logic clr);
		flag_next = set | (cur & ~clr);
	endfunction

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			mode    <= dmsi_mode_t'(MODE_RST);
			csrc    <= dmsi_csrc_t'(CSRC_RST);
			par_en  <= 1'b0;
			par_odd <= 1'b0;
		end else if (wr_mode) begin
			mode    <= dmsi_mode_t'(i_bus.wdata[MODE_LO_BIT +: 2]);
			csrc    <= dmsi_csrc_t'(i_bus.wdata[CSRC_LO_BIT +: 2]);
			par_en  <= i_bus.wdata[PAR_EN_BIT];
			par_odd <= i_bus.wdata[ODD_BIT];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			tx_en <= 1'b0;
			rx_en <= 1'b0;
		end else if (wr_ctrl) begin
			tx_en <= i_bus.wdata[TX_ENABLE_BIT];
			rx_en <= i_bus.wdata[RX_ENABLE_BIT];
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst)
			prio <= PRIO_RST;
		else if (wr_prio)
			prio <= i_bus.wdata[PRIO_LO_BIT +: 2];
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst)
			tx_data <= 8'h00;
		else if (wr_data)
			tx_data <= i_bus.wdata;
	end

	////////////////////////////////////////////////////////////////////
	// bit clock: oscillator divider or timer tick; slave uses far clock
	logic [4:0] div_cnt, div_ratio;
	logic       tick, half_tick;
	always_comb begin
		case (csrc)
			DMSI_CS_DIV4: div_ratio = DIV_4;
			DMSI_CS_DIV8: div_ratio = DIV_8;
			default:      div_ratio = DIV_16;
		endcase
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst || div_cnt == div_ratio - 5'h01)
			div_cnt <= 5'h00;
		else
			div_cnt <= div_cnt + 5'h01;
	end

	// slave clock edges: far side drives sclk, sample on its rising edge, shift out on its falling edge
	// both history bits reset to the idle high level, so no false edge after reset
	logic sclk_q, sin_q, slave_rise, slave_fall;
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			sclk_q <= 1'b1;
			sin_q  <= 1'b1;
		end else begin
			sclk_q <= i_link.sclk_in;
			sin_q  <= i_link.serial_in;
		end
	end
	assign slave_rise = i_link.sclk_in && !sclk_q;
	assign slave_fall = !i_link.sclk_in && sclk_q;

	logic osc_tick, osc_half;
	assign osc_tick = (csrc == DMSI_CS_TIMER) ? i_link.timer_tick : (div_cnt == 5'h00);
	assign osc_half = (csrc != DMSI_CS_TIMER) && (div_cnt == (div_ratio >> 1));
	assign tick      = (mode == DMSI_SYNC_SLAVE) ? slave_rise : osc_tick;
	assign half_tick = (mode == DMSI_SYNC_SLAVE) ? slave_fall : osc_half;

	////////////////////////////////////////////////////////////////////
	// transmitter
	dmsi_state_t tx_state;
	logic [3:0]  tx_cnt, tx_len;
	logic [10:0] tx_sr;
	logic        tx_par;
	assign tx_par = ^(mode == DMSI_ASYNC_7 ? {1'b0, tx_data[6:0]} : tx_data) ^ par_odd;
	assign tx_len = !is_async ? 4'd8 : (mode == DMSI_ASYNC_7 ? 4'd9 : 4'd10) + {3'b000, par_en};

	always_ff @(posedge i_mclk) begin
		if (i_rst || !tx_en) begin
			tx_state     <= DMSI_IDLE;
			tx_busy      <= 1'b0;
			tx_cnt       <= 4'h0;
			tx_sr        <= 11'h7ff;
			o_serial_out <= 1'b1;
		end else begin
			case (tx_state)
				DMSI_IDLE: if (tx_start) begin
					tx_busy  <= 1'b1;
					tx_cnt   <= 4'h0;
					tx_state <= DMSI_SHIFT;
					if (!is_async)
						tx_sr <= {3'b111, tx_data};
					else if (mode == DMSI_ASYNC_7)
						tx_sr <= par_en ? {2'b11, tx_par, tx_data[6:0], 1'b0}
						                : {3'b111, tx_data[6:0], 1'b0};
					else
						tx_sr <= par_en ? {1'b1, tx_par, tx_data, 1'b0}
						                : {2'b11, tx_data, 1'b0};
				end
				DMSI_SHIFT: if (is_async ? tick : half_tick) begin
					o_serial_out <= tx_sr[0];
					tx_sr        <= {1'b1, tx_sr[10:1]};
					tx_cnt       <= tx_cnt + 4'h1;
					if (tx_cnt == tx_len)
						tx_state <= DMSI_DONE;
				end
				DMSI_DONE: begin
					tx_busy      <= 1'b0;
					o_serial_out <= 1'b1;
					tx_state     <= DMSI_IDLE;
				end
				default: tx_state <= DMSI_IDLE;
			endcase
		end
	end

	// master clock out runs only while a sync character moves
	logic sync_act;
	assign sync_act = !is_async && (tx_busy || rx_busy);
	always_ff @(posedge i_mclk) begin
		if (i_rst || !sync_act)
			o_sclk_out <= 1'b1;
		else if (half_tick)
			o_sclk_out <= 1'b0;
		else if (tick)
			o_sclk_out <= 1'b1;
	end
	assign o_sclk_oe = (mode == DMSI_SYNC_MASTER);

	////////////////////////////////////////////////////////////////////
	// receiver; async samples mid-bit from the start edge on the oscillator sources
	dmsi_state_t rx_state;
	logic [3:0]  rx_cnt, rx_len;
	logic [9:0]  rx_sr;
	logic        rx_sample, rx_end, par_bad, stop_bad;
	assign rx_len = !is_async ? 4'd8 : (mode == DMSI_ASYNC_7 ? 4'd8 : 4'd9) + {3'b000, par_en};

	// bit timer restarts at the start edge; the free divider phase would drift off mid-bit
	logic [4:0] rx_ph;
	always_ff @(posedge i_mclk) begin
		if (i_rst || rx_state != DMSI_SHIFT || rx_ph == div_ratio - 5'h01)
			rx_ph <= 5'h00;
		else
			rx_ph <= rx_ph + 5'h01;
	end
	// timer source: samples on the tick, so its phase is the timer's own
	assign rx_sample = !is_async ? tick
	                 : (csrc == DMSI_CS_TIMER) ? i_link.timer_tick : (rx_ph == (div_ratio >> 1));

	always_ff @(posedge i_mclk) begin
		if (i_rst || !rx_en) begin
			rx_state <= DMSI_IDLE;
			rx_busy  <= 1'b0;
			rx_cnt   <= 4'h0;
			rx_sr    <= 10'h000;
		end else begin
			case (rx_state)
				DMSI_IDLE: begin
					if ((!is_async && rx_start) || (is_async && sin_q && !i_link.serial_in)) begin
						rx_busy  <= 1'b1;
						rx_cnt   <= 4'h0;
						rx_state <= DMSI_SHIFT;
					end
				end
				DMSI_SHIFT: if (rx_sample) begin
					if (!(is_async && rx_cnt == 4'h0))
						rx_sr <= {i_link.serial_in, rx_sr[9:1]};
					rx_cnt <= rx_cnt + 4'h1;
					if (rx_cnt == rx_len)
						rx_state <= DMSI_DONE;
				end
				DMSI_DONE: begin
					rx_busy  <= is_async; // async keeps listening
					rx_state <= DMSI_IDLE;
				end
				default: rx_state <= DMSI_IDLE;
			endcase
		end
	end
	assign rx_end = rx_en && rx_state == DMSI_DONE;

	// right-align the captured bits and split parity and stop
	logic [9:0] rx_al;
	always_comb begin
		// seven data bits and a stop, no parity: eight shifts, so one place higher
		if (!is_async || (mode == DMSI_ASYNC_7 && !par_en))
			rx_al = {2'b11, rx_sr[9:2]};
		else if (mode == DMSI_ASYNC_8 && par_en)
			rx_al = rx_sr;
		else
			rx_al = {1'b0, rx_sr[9:1]};
		rx_shift_out = (mode == DMSI_ASYNC_7) ? {1'b0, rx_al[6:0]} : rx_al[7:0];
		par_bad = par_en && ((mode == DMSI_ASYNC_7 ? ^rx_al[7:0] : ^rx_al[8:0]) != par_odd);
		stop_bad = !i_link.serial_in;
	end

	logic ovr_ev, perr_ev, ferr_ev, load_ev;
	assign ovr_ev  = rx_end && is_async && rx_buf_full;
	assign perr_ev = rx_end && is_async && par_bad;
	assign ferr_ev = rx_end && is_async && stop_bad;
	assign load_ev = rx_end && !ovr_ev;

	always_ff @(posedge i_mclk) begin
		if (i_rst)
			rx_buf <= 8'h00;
		else if (load_ev)
			rx_buf <= rx_shift_out;
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst || !rx_en || !is_async)
			rx_buf_full <= 1'b0;
		else if (load_ev)
			rx_buf_full <= 1'b1;
		else if (rx_start)
			rx_buf_full <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// error and event flags
	always_ff @(posedge i_mclk) begin
		if (i_rst || !rx_en) begin
			ovr  <= 1'b0;
			perr <= 1'b0;
			ferr <= 1'b0;
		end else begin
			ovr  <= flag_next(ovr, ovr_ev, wr_ctrl && i_bus.wdata[OVR_BIT]);
			perr <= flag_next(perr, perr_ev, wr_ctrl && i_bus.wdata[PERR_BIT]);
			ferr <= flag_next(ferr, ferr_ev, wr_ctrl && i_bus.wdata[FERR_BIT]);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			tx_done <= 1'b0;
			rx_done <= 1'b0;
			rx_err  <= 1'b0;
		end else begin
			tx_done <= flag_next(tx_done, tx_state == DMSI_DONE,
			                     wr_evt && i_bus.wdata[TXDONE_BIT]);
			rx_done <= flag_next(rx_done, load_ev, wr_evt && i_bus.wdata[RXDONE_BIT]);
			rx_err  <= flag_next(rx_err, ovr_ev | perr_ev | ferr_ev,
			                     wr_evt && i_bus.wdata[RXERR_BIT]);
		end
	end

	// ready low from the rx_trigger write until the character is in
	always_ff @(posedge i_mclk) begin
		if (i_rst || mode != DMSI_SYNC_SLAVE || !rx_en)
			o_slave_ready_n <= 1'b1;
		else if (rx_start)
			o_slave_ready_n <= 1'b0;
		else if (rx_end)
			o_slave_ready_n <= 1'b1;
	end

	assign o_irq_level = ((tx_done | rx_done | rx_err) && prio != 2'b00) ? prio : 2'b00;

	////////////////////////////////////////////////////////////////////
	// read data, one cycle after the strobe
	always_ff @(posedge i_mclk) begin
		if (i_rst || !i_bus.rd)
			o_rdata <= 8'h00;
		else begin
			case (i_bus.addr)
				ADDR_MODE:     o_rdata <= {1'b0, par_en, par_odd, csrc, mode, 1'b0};
				ADDR_CTRL:     o_rdata <= {1'b0, ferr, perr, ovr, rx_busy, rx_en, tx_busy, tx_en};
				ADDR_DATA:     o_rdata <= rx_buf;
				ADDR_EVENTS:   o_rdata <= {5'h00, rx_err, rx_done, tx_done};
				ADDR_IRQ_PRIO: o_rdata <= {2'b00, prio, 4'h0};
				default:       o_rdata <= 8'h00;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	property p_tx_busy_start; tx_start |=> tx_busy; endproperty
	a_tx_busy_start: assert property (p_tx_busy_start) else $error("tx busy not set");
	property p_flags_off; !rx_en |=> !(ovr | perr | ferr); endproperty
	a_flags_off: assert property (p_flags_off) else $error("error flag while rx off");
	property p_ovr_set; ovr_ev && rx_en |=> ovr; endproperty
	a_ovr_set: assert property (p_ovr_set) else $error("overrun lost");
	property p_ready; rx_start && mode == DMSI_SYNC_SLAVE |=> !o_slave_ready_n; endproperty
	a_ready: assert property (p_ready) else $error("slave ready not low");
	property p_idle_high; !tx_en |=> o_serial_out; endproperty
	a_idle_high: assert property (p_idle_high) else $error("line not idle high");
	property p_rx7_msb; load_ev && mode == DMSI_ASYNC_7 |=> !rx_buf[7]; endproperty
	a_rx7_msb: assert property (p_rx7_msb) else $error("7-bit msb not zero");
	property p_rx_err; (perr_ev || ferr_ev) |=> rx_err; endproperty
	a_rx_err: assert property (p_rx_err) else $error("rx error flag missed");
	property p_rx_done; load_ev |=> rx_done && rx_buf == $past(rx_shift_out); endproperty
	a_rx_done: assert property (p_rx_done) else $error("rx done missed");

endmodule : dmsi_serial

`default_nettype wire

// ---- dmsi_pkg.sv ----
// package for the dual mode serial interface: register map, fields, states
package dmsi_pkg;

	localparam logic [15:0] ADDR_IRQ_PRIO = 16'hff20;
	localparam logic [15:0] ADDR_MODE     = 16'hff48;
	localparam logic [15:0] ADDR_CTRL     = 16'hff49;
	localparam logic [15:0] ADDR_DATA     = 16'hff4a;
	localparam logic [15:0] ADDR_EVENTS   = 16'hff4b;

	// field positions in serial_mode_config
	localparam int MODE_LO_BIT = 1;
	localparam int CSRC_LO_BIT = 3;
	localparam int ODD_BIT     = 5;
	localparam int PAR_EN_BIT  = 6;
	// field positions in serial_control_status
	localparam int TX_ENABLE_BIT    = 0;
	localparam int TX_TRIGGER_BIT   = 1;
	localparam int RX_ENABLE_BIT    = 2;
	localparam int RX_TRIGGER_BIT   = 3;
	localparam int OVR_BIT     = 4;
	localparam int PERR_BIT    = 5;
	localparam int FERR_BIT    = 6;
	// field position in serial_irq_priority
	localparam int PRIO_LO_BIT = 4;
	// field positions in the event register
	localparam int TXDONE_BIT  = 0;
	localparam int RXDONE_BIT  = 1;
	localparam int RXERR_BIT   = 2;

	localparam logic [1:0] MODE_RST = 2'h0;
	localparam logic [1:0] CSRC_RST = 2'h0;
	localparam logic [1:0] PRIO_RST = 2'h0;

	// oscillator divide ratios, in high_osc_freq (i_mclk) cycles per bit
	localparam logic [4:0] DIV_4  = 5'h04;
	localparam logic [4:0] DIV_8  = 5'h08;
	localparam logic [4:0] DIV_16 = 5'h10;

	typedef enum logic [1:0] {
		DMSI_SYNC_MASTER = 2'b00,
		DMSI_SYNC_SLAVE  = 2'b01,
		DMSI_ASYNC_7     = 2'b10,
		DMSI_ASYNC_8     = 2'b11
	} dmsi_mode_t;

	typedef enum logic [1:0] {
		DMSI_CS_DIV16 = 2'b00,
		DMSI_CS_DIV8  = 2'b01,
		DMSI_CS_DIV4  = 2'b10,
		DMSI_CS_TIMER = 2'b11
	} dmsi_csrc_t;

	typedef enum logic [1:0] {
		DMSI_IDLE  = 2'b00,
		DMSI_SHIFT = 2'b01,
		DMSI_DONE  = 2'b10
	} dmsi_state_t;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} dmsi_bus_t;

	typedef struct packed {
		logic serial_in;
		logic sclk_in;
		logic timer_tick;
	} dmsi_link_in_t;

endpackage : dmsi_pkg

// ---- dmsi_peer.sv ----
// serial peer model: drives frames into the device and captures its frames
`timescale 1ns/1ps
`default_nettype none

module dmsi_peer #(
	parameter int BIT = 16
) (
	// clock
	input  wire logic i_mclk,
	// link
	input  wire logic i_line,
	output var logic  o_line,
	output var logic  o_sclk,
	output var logic  o_tick
);
	// line idles high; clock parked, timer source not modelled
	initial begin
		o_line = 1'b1;
		o_sclk = 1'b1;
		o_tick = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// start low, n bits lsb first, then the chosen stop level
	task automatic send(input logic [8:0] d, input int n, input logic stop);
		o_line <= 1'b0;
		repeat (BIT) @(posedge i_mclk);
		for (int k = 0; k <= n; k++) begin
			o_line <= (k == n) ? stop : d[k];
			repeat (BIT) @(posedge i_mclk);
		end
		o_line <= 1'b1;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// bounded hunt for a start bit, then n bits and the stop bit at mid-bit
	task automatic grab(input int n, output logic [9:0] f);
		int t;
		f = '1;
		t = 0;
		while (i_line && t < 64 * BIT) begin
			@(posedge i_mclk);
			t++;
		end
		repeat (BIT / 2) @(posedge i_mclk);
		for (int k = 0; k <= n; k++) begin
			repeat (BIT) @(posedge i_mclk);
			f[k] = i_line;
		end
	endtask
endmodule // dmsi_peer

`default_nettype wire

// ---- test_dmsi_serial.sv ----
// testbench: registers, async transmit and receive, errors, slave ready
`timescale 1ns/1ps
`default_nettype none

module test_dmsi_serial;
	import dmsi_pkg::*;

	logic          i_mclk;
	logic          i_rst;
	dmsi_bus_t     bus;
	wire dmsi_link_in_t link;
	logic [7:0]    rdata;
	logic          serial_out;
	logic          sclk_out;
	logic          sclk_oe;
	logic          slave_ready_n;
	logic [1:0]    irq_level;
	int            fail_count;
	int            checked;
	logic [7:0]    v;
	logic [9:0]    f;

	dmsi_serial i_dmsi_serial (
		.i_mclk          (i_mclk),
		.i_rst           (i_rst),
		.i_bus           (bus),
		.o_rdata         (rdata),
		.i_link          (link),
		.o_serial_out    (serial_out),
		.o_sclk_out      (sclk_out),
		.o_sclk_oe       (sclk_oe),
		.o_slave_ready_n (slave_ready_n),
		.o_irq_level     (irq_level)
	);

	dmsi_peer #(.BIT(int'(DIV_16))) i_dmsi_peer (
		.i_mclk (i_mclk),
		.i_line (serial_out),
		.o_line (link.serial_in),
		.o_sclk (link.sclk_in),
		.o_tick (link.timer_tick)
	);

	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (fail_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [9:0] exp, input logic [9:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_mclk);
		bus <= '0;
	endtask

	// data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a);
		@(posedge i_mclk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge i_mclk);
		bus <= '0;
		#1 v = rdata;
	endtask

	task automatic chk(input string name, input logic [15:0] a, input logic [7:0] exp);
		rd(a);
		check(name, 10'(exp), 10'(v));
	endtask

	// bounded poll; a miss ends the run
	task automatic wait_ev(input int b);
		int t;
		t = 0;
		v = '0;
		while (v[b] !== 1'b1 && t < 400) begin
			rd(ADDR_EVENTS);
			t++;
		end
		if (v[b] !== 1'b1) begin
			check("event wait", 10'(b), 10'h3ff);
			stop_test();
		end
		check("irq level", 10'h3, 10'(irq_level));
	endtask

	function automatic logic [7:0] cfg(input dmsi_mode_t m, input logic p, input logic o);
		return (8'(m) << MODE_LO_BIT) | (8'(p) << PAR_EN_BIT) | (8'(o) << ODD_BIT);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	task automatic tx(input dmsi_mode_t m, input logic p, input logic o, input logic [7:0] d);
		int         nb;
		logic [9:0] e;
		nb = (m == DMSI_ASYNC_7) ? 7 : 8;
		e = '1;
		for (int k = 0; k < nb; k++)
			e[k] = d[k];
		if (p)
			e[nb] = ^(d & (8'hff >> (8 - nb))) ^ o;
		wr(ADDR_MODE, cfg(m, p, o));
		wr(ADDR_DATA, d);
		wr(ADDR_CTRL, 8'h03);
		fork
			i_dmsi_peer.grab(nb + p, f);
			chk("tx busy", ADDR_CTRL, 8'h03);
		join
		check("tx frame", e, f);
		wait_ev(TXDONE_BIT);
		wr(ADDR_EVENTS, 8'h07);
		chk("tx idle", ADDR_CTRL, 8'h01);
	endtask

	// late done or error events are let through before clearing
	task automatic rx(input dmsi_mode_t m, input logic p, input logic o, input logic [8:0] d,
			input logic stop, input logic [7:0] eb, input logic [7:0] ef, input int ev);
		wr(ADDR_MODE, cfg(m, p, o));
		wr(ADDR_CTRL, 8'h7c);
		i_dmsi_peer.send(d, (m == DMSI_ASYNC_7 ? 7 : 8) + p, stop);
		wait_ev(ev);
		if (ev == RXDONE_BIT)
			chk("rx data", ADDR_DATA, eb);
		rd(ADDR_CTRL);
		check("rx flags", 10'(ef), 10'(v & 8'h70));
		repeat (32) @(posedge i_mclk);
		wr(ADDR_CTRL, 8'h7c);
		wr(ADDR_EVENTS, 8'h07);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		i_rst = 1'b1;
		bus = '0;
		fail_count = 0;
		checked = 0;
		repeat (12) @(posedge i_mclk);
		i_rst <= 1'b0;
		chk("mode reset", ADDR_MODE, 8'h00);
		check("master clock drive", 10'h1, 10'(sclk_oe));
		check("master clock idle", 10'h1, 10'(sclk_out));
		chk("ctrl reset", ADDR_CTRL, 8'h00);
		chk("prio reset", ADDR_IRQ_PRIO, 8'h00);
		chk("unmapped", 16'hff30, 8'h00);
		wr(ADDR_MODE, 8'h7e);
		chk("mode rw", ADDR_MODE, 8'h7e);
		wr(ADDR_IRQ_PRIO, 8'h30);
		chk("prio rw", ADDR_IRQ_PRIO, 8'h30);
		wr(ADDR_CTRL, 8'h01);
		chk("tx enable", ADDR_CTRL, 8'h01);
		tx(DMSI_ASYNC_8, 1'b0, 1'b0, 8'ha5);
		tx(DMSI_ASYNC_7, 1'b1, 1'b0, 8'hd3);
		tx(DMSI_ASYNC_7, 1'b1, 1'b1, 8'hd3);
		tx(DMSI_ASYNC_8, 1'b1, 1'b1, 8'h5a);
		rx(DMSI_ASYNC_8, 1'b0, 1'b0, 9'h03c, 1'b1, 8'h3c, 8'h00, RXDONE_BIT);
		rx(DMSI_ASYNC_7, 1'b1, 1'b1, 9'h0d5, 1'b1, 8'h55, 8'h00, RXDONE_BIT);
		rx(DMSI_ASYNC_7, 1'b0, 1'b0, 9'h04b, 1'b1, 8'h4b, 8'h00, RXDONE_BIT);
		rx(DMSI_ASYNC_8, 1'b1, 1'b1, 9'h1a5, 1'b1, 8'ha5, 8'h00, RXDONE_BIT);
		rx(DMSI_ASYNC_8, 1'b1, 1'b0, 9'h13c, 1'b1, 8'h00, 8'h20, RXERR_BIT);
		rx(DMSI_ASYNC_8, 1'b0, 1'b0, 9'h0a5, 1'b0, 8'h00, 8'h40, RXERR_BIT);
		// second character with the buffer still full
		wr(ADDR_MODE, cfg(DMSI_ASYNC_8, 1'b0, 1'b0));
		wr(ADDR_CTRL, 8'h7c);
		i_dmsi_peer.send(9'h011, 8, 1'b1);
		wait_ev(RXDONE_BIT);
		wr(ADDR_EVENTS, 8'h07);
		i_dmsi_peer.send(9'h022, 8, 1'b1);
		wait_ev(RXERR_BIT);
		chk("overrun", ADDR_CTRL, 8'h1c);
		chk("kept data", ADDR_DATA, 8'h11);
		chk("no rx done", ADDR_EVENTS, 8'h04);
		wr(ADDR_CTRL, 8'h00);
		chk("flags off", ADDR_CTRL, 8'h00);
		wr(ADDR_MODE, cfg(DMSI_SYNC_SLAVE, 1'b0, 1'b0));
		wr(ADDR_CTRL, 8'h04);
		#1 check("ready idle", 10'h1, 10'(slave_ready_n));
		check("slave clock drive", 10'h0, 10'(sclk_oe));
		wr(ADDR_CTRL, 8'h0c);
		repeat (2) @(posedge i_mclk);
		#1 check("ready low", 10'h0, 10'(slave_ready_n));
		chk("sync rx busy", ADDR_CTRL, 8'h0c);
		stop_test();
	end
endmodule // test_dmsi_serial

`default_nettype wire
